// >>> rtl/cslt_enc8b10b.sv
// one-lane 8b/10b encoder with running disparity
// assumes k octets are only K28.0/3/4/5/7
`timescale 1ns/1ps
`include "cslt_params.svh"
module cslt_enc8b10b (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire cslt_pkg::cslt_oct_t octIn,
  output logic [9:0] sym
);
  import cslt_pkg::*;
  // tables hold the negative-disparity forms, bit a first
  localparam logic [5:0] T6 [32] = '{
    6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
    6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
  localparam logic [3:0] T4 [8] = '{
    4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};
  cslt_enc_st_t s, n;
  logic [5:0] c6;
  logic [3:0] c4;
  logic [9:0] kc;
  logic rd6, u6, u4, a7;
  logic [4:0] x;
  logic [2:0] y;
  always_comb begin
    n = s;
    x = octIn.d[4:0];
    y = octIn.d[7:5];
    c6 = T6[x];
    u6 = $countones(c6) != 3;
    if (s.rd && (u6 || x == 5'h07)) c6 = ~c6;
    rd6 = s.rd ^ u6;
    a7 = rd6 ? (x == 5'h0b || x == 5'h0d || x == 5'h0e)
              : (x == 5'h11 || x == 5'h12 || x == 5'h14);
    c4 = (y == 3'h7 && a7) ? 4'h7 : T4[y];
    u4 = $countones(c4) != 2;
    if (rd6 && (u4 || y == 3'h3)) c4 = ~c4;
    case (octIn.d)
      `CSLT_K28_0: kc = 10'h0f4;
      `CSLT_K28_3: kc = 10'h0f3;
      `CSLT_K28_4: kc = 10'h0f2;
      `CSLT_K28_7: kc = 10'h0f8;
      default: kc = 10'h0fa;
    endcase
    if (octIn.k) begin
      n.sym = s.rd ? ~kc : kc;
      n.rd = s.rd ^ ($countones(kc) != 5);
    end else begin
      n.sym = {c6, c4};
      n.rd = rd6 ^ u4;
    end
  end
  always_ff @(posedge clk) begin
    if (!rstn) s <= '0;
    else if (ce) s <= n;
  end
  assign sym = s.sym;
  property p_dispBal;
    @(posedge clk) disable iff (!rstn)
    ce |=> (($countones(s.sym) == 5) == (s.rd == $past(s.rd)));
  endproperty
  a_dispBal: assert property (p_dispBal)
    else $error("disparity does not follow symbol");
endmodule

// >>> rtl/cslt_link_tx.sv
// link transmit block: framing, scrambling, character
// replacement, sync and alignment sequences, apb registers
// assumes samples and link inputs synchronous to clk
`timescale 1ns/1ps
`include "cslt_params.svh"
module cslt_link_tx (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire cslt_pkg::cslt_apb_req_t apbReq,
  output cslt_pkg::cslt_apb_rsp_t apbRsp,
  input wire cslt_pkg::cslt_smp_t samples,
  output logic sampleTake,
  input wire logic sysref,
  input wire logic receiverSyncRequestN,
  output logic [3:0] laneActive,
  output logic [3:0][9:0] laneSym
);
  import cslt_pkg::*;

  cslt_state_t s, n;
  cslt_oct_t [3:0] octs;
  logic [3:0][7:0] datOct;
  logic [2:0] fMx, halfF, si3;
  logic [1:0] si, cv;
  logic [7:0] pos, raw;
  logic [22:0] sc;
  logic lastOct, lastFr, mfEnd, sysRise, acc;

  function automatic logic [2:0] fMax(input logic [1:0] md);
    case (md)
      `CSLT_MODE_1L: fMax = `CSLT_F1_M1;
      `CSLT_MODE_2L: fMax = `CSLT_F2_M1;
      default: fMax = `CSLT_F4_M1;
    endcase
  endfunction

  function automatic logic [4:0] lM1(input logic [1:0] md);
    case (md)
      `CSLT_MODE_1L: lM1 = `CSLT_L1_M1;
      `CSLT_MODE_2L: lM1 = `CSLT_L2_M1;
      default: lM1 = `CSLT_L4_M1;
    endcase
  endfunction

  function automatic logic [3:0] actMask(input logic [1:0] md);
    case (md)
      `CSLT_MODE_1L: actMask = `CSLT_ACT_1L;
      `CSLT_MODE_2L: actMask = `CSLT_ACT_2L;
      default: actMask = `CSLT_ACT_4L;
    endcase
  endfunction

  // serial form taken msb first, feedback from sent bits
  function automatic logic [22:0] scr8(input logic [14:0] st,
                                       input logic [7:0] d);
    logic [14:0] t;
    logic [7:0] o;
    logic b;
    t = st;
    o = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      b = d[i] ^ t[13] ^ t[14];
      o[i] = b;
      t = {t[13:0], b};
    end
    return {t, o};
  endfunction

  function automatic logic [7:0] chk(input logic [1:0] ln,
                                     input logic [1:0] md,
                                     input logic scn,
                                     input logic [4:0] km);
    chk = `CSLT_DID + 8'(`CSLT_BID) + 8'(ln) + 8'(scn)
      + 8'(lM1(md)) + 8'(fMax(md)) + 8'(km) + `CSLT_M_M1
      + 8'(`CSLT_CS) + 8'(`CSLT_N_M1) + 8'(`CSLT_SUBCL)
      + 8'(`CSLT_NP_M1) + 8'(`CSLT_JESDV) + 8'(`CSLT_S_M1)
      + 8'(`CSLT_HD) + 8'(`CSLT_CF);
  endfunction

  function automatic logic [7:0] cfgOct(input logic [3:0] i,
                                        input logic [1:0] ln,
                                        input logic [1:0] md,
                                        input logic scn,
                                        input logic [4:0] km);
    case (i)
      4'h0: cfgOct = `CSLT_DID;
      4'h1: cfgOct = {4'h0, `CSLT_BID};
      4'h2: cfgOct = {6'h00, ln};
      4'h3: cfgOct = {scn, 2'h0, lM1(md)};
      4'h4: cfgOct = {5'h00, fMax(md)};
      4'h5: cfgOct = {3'h0, km};
      4'h6: cfgOct = `CSLT_M_M1;
      4'h7: cfgOct = {`CSLT_CS, 1'b0, `CSLT_N_M1};
      4'h8: cfgOct = {`CSLT_SUBCL, `CSLT_NP_M1};
      4'h9: cfgOct = {`CSLT_JESDV, `CSLT_S_M1};
      4'ha: cfgOct = {`CSLT_HD, 2'h0, `CSLT_CF};
      4'hd: cfgOct = chk(ln, md, scn, km);
      default: cfgOct = 8'h00;
    endcase
  endfunction

  function automatic logic regHit(input logic [7:0] a);
    regHit = a == `CSLT_REG_CTRL || a == `CSLT_REG_MAP
          || a == `CSLT_REG_FCHK || a == `CSLT_REG_STAT;
  endfunction

  always_comb begin
    n = s;
    octs = '0;
    datOct = '0;
    raw = 8'h00;
    sc = '0;
    si3 = 3'h0;
    si = 2'h0;
    cv = 2'h0;
    fMx = fMax(s.mode);
    halfF = 3'((4'(fMx) + 4'h1) >> 1);
    lastOct = s.oct >= fMx;
    lastFr = s.fr >= s.kM1;
    mfEnd = lastOct && lastFr;
    sysRise = sysref && !s.sysD;
    pos = 8'(s.fr) * (8'(fMx) + 8'h01) + 8'(s.oct);

    for (int l = 0; l < 4; l++) begin
      // two octets per sample, samples packed lane by lane
      si3 = 3'(3'(l) * halfF) + 3'(s.oct >> 1);
      si = si3[1:0];
      cv = s.map[{si, 1'b0} +: 2];
      // sample is pure 16-bit data, no control or tail
      raw = s.oct[0] ? s.smp[cv][7:0]
                     : s.smp[cv][15:8];
      sc = scr8(s.scr[l], raw);
      datOct[l] = s.scrEn ? sc[7:0] : raw;
      case (s.phase)
        PH_DATA: begin
          octs[l] = {1'b0, datOct[l]};
          if (s.scrEn) n.scr[l] = sc[22:8];
          if (lastOct) begin
            n.prev[l] = datOct[l];
            if (!s.scrEn && datOct[l] == s.prev[l])
              octs[l] = {1'b1, lastFr ? `CSLT_K28_3
                                      : `CSLT_K28_7};
            if (s.scrEn && lastFr && datOct[l] == `CSLT_K28_3)
              octs[l] = {1'b1, `CSLT_K28_3};
            if (s.scrEn && !lastFr && datOct[l] == `CSLT_K28_7)
              octs[l] = {1'b1, `CSLT_K28_7};
          end
        end
        PH_ILAS: begin
          // ramp keeps counting under the config octets
          octs[l] = {1'b0, s.ramp};
          if (s.oct == 3'h0 && s.fr == 5'h00)
            octs[l] = {1'b1, `CSLT_K28_0};
          else if (mfEnd)
            octs[l] = {1'b1, `CSLT_K28_3};
          else if (s.mf == `CSLT_CFG_MF && pos == `CSLT_Q_POS)
            octs[l] = {1'b1, `CSLT_K28_4};
          else if (s.mf == `CSLT_CFG_MF && pos >= `CSLT_CFG_FIRST
                   && pos <= `CSLT_CFG_LAST)
            octs[l] = {1'b0, cfgOct(4'(pos - `CSLT_CFG_FIRST),
              2'(l), s.mode, s.scrEn, s.kM1)};
        end
        default: octs[l] = {1'b1, `CSLT_K28_5};
      endcase
    end

    // sysref edge realigns the local multiframe clock
    n.sysD = sysref;
    if (sysRise) begin
      n.oct = 3'h0;
      n.fr = 5'h00;
    end else begin
      n.oct = lastOct ? 3'h0 : s.oct + 3'h1;
      if (lastOct) n.fr = lastFr ? 5'h00 : s.fr + 5'h01;
    end
    if (lastOct) n.smp = samples;
    n.take = n.oct == fMx;

    if (!receiverSyncRequestN) begin
      n.phase = PH_CGS;
      n.bcnt = 1'b0;
    end else begin
      case (s.phase)
        PH_CGS: begin
          if (mfEnd) begin
            if (s.bcnt) begin
              n.phase = PH_ILAS;
              n.mf = 2'h0;
              n.ramp = 8'h00;
            end else begin
              n.bcnt = 1'b1;
            end
          end
        end
        PH_ILAS: begin
          n.ramp = s.ramp + 8'h01;
          if (mfEnd) begin
            n.mf = s.mf + 2'h1;
            if (s.mf == `CSLT_ILAS_LAST) n.phase = PH_DATA;
          end
        end
        default: n.phase = s.phase;
      endcase
    end

    // answer one cycle into the access phase
    acc = apbReq.psel && apbReq.penable;
    n.rsp.pready = acc && !s.rsp.pready;
    n.rsp.pslverr = 1'b0;
    if (acc && !s.rsp.pready) begin
      n.rsp.pslverr = !regHit(apbReq.paddr);
      n.rsp.prdata = '0;
      case (apbReq.paddr)
        `CSLT_REG_CTRL: begin
          n.rsp.prdata[`CSLT_CTRL_MODE +: 2] = s.mode;
          n.rsp.prdata[`CSLT_CTRL_SCR] = s.scrEn;
          n.rsp.prdata[`CSLT_CTRL_K +: 5] = s.kM1;
        end
        `CSLT_REG_MAP: n.rsp.prdata[7:0] = s.map;
        `CSLT_REG_FCHK:
          n.rsp.prdata[7:0] = chk(2'h0, s.mode, s.scrEn, s.kM1);
        `CSLT_REG_STAT: begin
          n.rsp.prdata[`CSLT_ST_PH +: 2] = 2'(s.phase);
          n.rsp.prdata[`CSLT_ST_MF +: 2] = s.mf;
          n.rsp.prdata[`CSLT_ST_OCT +: 3] = s.oct;
          n.rsp.prdata[`CSLT_ST_FR +: 5] = s.fr;
        end
        default: n.rsp.prdata = '0;
      endcase
    end
    if (acc && s.rsp.pready && apbReq.pwrite) begin
      case (apbReq.paddr)
        `CSLT_REG_CTRL: begin
          n.mode = apbReq.pwdata[`CSLT_CTRL_MODE +: 2];
          n.scrEn = apbReq.pwdata[`CSLT_CTRL_SCR];
          n.kM1 = apbReq.pwdata[`CSLT_CTRL_K +: 5];
        end
        `CSLT_REG_MAP: n.map = apbReq.pwdata[7:0];
        default: n.map = s.map;
      endcase
    end
    n.act = actMask(n.mode);
  end

  // reset wins over the clock enable
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s <= '0;
      s.mode <= `CSLT_MODE_1L;
      s.act <= `CSLT_ACT_1L;
      s.kM1 <= `CSLT_KM1_RST;
      s.map <= `CSLT_MAP_RST;
    end else if (ce) begin
      s <= n;
    end
  end

  for (genvar g = 0; g < 4; g++) begin : gLane
    cslt_enc8b10b uEnc (
      .clk(clk),
      .rstn(rstn),
      .ce(ce),
      .octIn(octs[g]),
      .sym(laneSym[g])
    );
  end

  assign apbRsp = s.rsp;
  assign sampleTake = s.take;
  assign laneActive = s.act;

  property p_cgsIdle;
    @(posedge clk) disable iff (!rstn)
    s.phase == PH_CGS |-> octs[3] == {1'b1, `CSLT_K28_5};
  endproperty
  a_cgsIdle: assert property (p_cgsIdle)
    else $error("lane not idle during code sync");

  property p_ilasStart;
    @(posedge clk) disable iff (!rstn)
    ce && receiverSyncRequestN && s.phase == PH_CGS
      && s.bcnt && mfEnd
      |=> s.phase == PH_ILAS && s.oct == 3'h0 && s.fr == 5'h00;
  endproperty
  a_ilasStart: assert property (p_ilasStart)
    else $error("alignment sequence did not start");

  property p_ilasEnd;
    @(posedge clk) disable iff (!rstn)
    ce && receiverSyncRequestN && s.phase == PH_ILAS
      && s.mf == 2'h3 && mfEnd |=> s.phase == PH_DATA;
  endproperty
  a_ilasEnd: assert property (p_ilasEnd)
    else $error("alignment sequence not four multiframes");

  property p_octWrap;
    @(posedge clk) disable iff (!rstn)
    ce && !sysRise && s.oct == fMax(s.mode) |=> s.oct == 3'h0;
  endproperty
  a_octWrap: assert property (p_octWrap)
    else $error("frame length wrong");

  property p_resetCfg;
    @(posedge clk) disable iff (!rstn)
    $rose(rstn) |-> s.mode == `CSLT_MODE_1L
      && laneActive == `CSLT_ACT_1L;
  endproperty
  a_resetCfg: assert property (p_resetCfg)
    else $error("reset configuration not one lane");

  property p_scrHold;
    @(posedge clk) disable iff (!rstn)
    ce && s.phase != PH_DATA |=> s.scr == $past(s.scr);
  endproperty
  a_scrHold: assert property (p_scrHold)
    else $error("scrambler moved outside data phase");

  property p_repA;
    @(posedge clk) disable iff (!rstn)
    s.phase == PH_DATA && !s.scrEn && mfEnd
      && datOct[0] == s.prev[0]
      |-> octs[0] == {1'b1, `CSLT_K28_3};
  endproperty
  a_repA: assert property (p_repA)
    else $error("multiframe end not replaced");

  property p_repF;
    @(posedge clk) disable iff (!rstn)
    s.phase == PH_DATA && s.scrEn && lastOct && !lastFr
      && datOct[0] == `CSLT_K28_7 |-> octs[0].k;
  endproperty
  a_repF: assert property (p_repF)
    else $error("scrambled frame end not replaced");
endmodule

// >>> rtl/cslt_params.svh
// constants for the converter serial link transmitter
// assumes 50 MHz clk; included by rtl files and the bench
// Notes on behaviour
// - frame octets, optional scramble, then 8b/10b
// - one, two or four lanes supported
// - S=1, M=4, N=16, N'=16, CF=CS=HD=0
// - octets per frame 8, 4, 2 by lanes
// - frames per multiframe set by software
// - scrambler enable is a software setting
// - link checksum computed, readable by software
// - reset config: four converters, one lane
// - converter to lane path mapping reconfigurable
// - sample split: MSB octet first, then LSB
// - scrambler self-synchronizing, 1 + x^14 + x^15
// - each octet becomes one 10-bit symbol
// - unscrambled repeat at multiframe end: K28.3
// - unscrambled repeat at other frame ends: K28.7
// - scrambled 0x7C at multiframe end: K28.3
// - scrambled 0xFC at other frame ends: K28.7
// - both ends use identical link parameters
// - sync characters first, alignment markers afterwards
// - no control or tail bits in samples
// - K28.5 on every lane during code sync
// - alignment sequence: second boundary, four multiframes
// - scrambling only during data phase
`ifndef CSLT_PARAMS_SVH
`define CSLT_PARAMS_SVH
`define CSLT_REG_CTRL 8'h00
`define CSLT_REG_MAP 8'h04
`define CSLT_REG_FCHK 8'h08
`define CSLT_REG_STAT 8'h0c
`define CSLT_CTRL_MODE 0
`define CSLT_CTRL_SCR 2
`define CSLT_CTRL_K 8
`define CSLT_ST_PH 0
`define CSLT_ST_MF 4
`define CSLT_ST_OCT 8
`define CSLT_ST_FR 16
`define CSLT_MODE_1L 2'h0
`define CSLT_MODE_2L 2'h1
`define CSLT_ACT_1L 4'h1
`define CSLT_ACT_2L 4'h3
`define CSLT_ACT_4L 4'hf
`define CSLT_F1_M1 3'h7
`define CSLT_F2_M1 3'h3
`define CSLT_F4_M1 3'h1
`define CSLT_L1_M1 5'h00
`define CSLT_L2_M1 5'h01
`define CSLT_L4_M1 5'h03
`define CSLT_KM1_RST 5'h1f
`define CSLT_MAP_RST 8'he4
`define CSLT_K28_0 8'h1c
`define CSLT_K28_3 8'h7c
`define CSLT_K28_4 8'h9c
`define CSLT_K28_5 8'hbc
`define CSLT_K28_7 8'hfc
`define CSLT_ILAS_LAST 2'h3
`define CSLT_CFG_MF 2'h1
`define CSLT_Q_POS 8'h01
`define CSLT_CFG_FIRST 8'h02
`define CSLT_CFG_LAST 8'h0f
// device and bank ids: arbitrary values
`define CSLT_DID 8'h00
`define CSLT_BID 4'h0
`define CSLT_M_M1 8'h03
`define CSLT_N_M1 5'h0f
`define CSLT_NP_M1 5'h0f
`define CSLT_S_M1 5'h00
`define CSLT_SUBCL 3'h1
`define CSLT_JESDV 3'h1
`define CSLT_CS 2'h0
`define CSLT_CF 5'h00
`define CSLT_HD 1'h0
`endif

// >>> rtl/cslt_pkg.sv
// types shared by the link transmitter files
// assumes cslt_params.svh holds all numeric constants
package cslt_pkg;
  typedef enum logic [1:0] {PH_CGS, PH_ILAS, PH_DATA} cslt_phase_t;
  typedef struct packed {
    logic k;
    logic [7:0] d;
  } cslt_oct_t;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } cslt_apb_req_t;
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } cslt_apb_rsp_t;
  typedef logic [3:0][15:0] cslt_smp_t;
  typedef struct packed {
    logic [9:0] sym;
    logic rd;
  } cslt_enc_st_t;
  typedef struct packed {
    cslt_phase_t phase;
    logic [2:0] oct;
    logic [4:0] fr;
    logic [1:0] mf;
    logic bcnt;
    logic [7:0] ramp;
    logic sysD;
    logic [1:0] mode;
    logic scrEn;
    logic [4:0] kM1;
    logic [7:0] map;
    logic [3:0] act;
    logic take;
    cslt_smp_t smp;
    logic [3:0][7:0] prev;
    logic [3:0][14:0] scr;
    cslt_apb_rsp_t rsp;
  } cslt_state_t;
endpackage

// >>> tb/cslt_link_tx_tb.sv
// self-checking bench for the link transmit block
// assumes cslt_rx_model as far side, 50 MHz clock
`timescale 1ns/1ps
`include "cslt_params.svh"
module cslt_link_tx_tb;
  import cslt_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic goLink = 1'b0;
  cslt_apb_req_t apbReq = '0;
  cslt_apb_rsp_t apbRsp;
  cslt_smp_t samples = '0;
  logic sampleTake, sysref, receiverSyncRequestN;
  logic [3:0] laneActive;
  logic [3:0][9:0] laneSym;
  int num_errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  int c0;
  logic [31:0] lfsr = 32'hf2f6_26f0;
  logic [31:0] rd;
  logic err;
  logic [3:0] kLog [0:4095];

  always #10 clk = ~clk;
  cslt_link_tx dut_u (.clk(clk), .rstn(rstn), .ce(1'b1), .apbReq(apbReq),
    .apbRsp(apbRsp), .samples(samples), .sampleTake(sampleTake),
    .sysref(sysref), .receiverSyncRequestN(receiverSyncRequestN),
    .laneActive(laneActive), .laneSym(laneSym));
  cslt_rx_model rx_u (.clk(clk), .rstn(rstn), .goLink(goLink),
    .laneActive(laneActive), .laneSym(laneSym), .sysref(sysref),
    .receiverSyncRequestN(receiverSyncRequestN));

  function automatic logic [31:0] nextRnd(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // K28.y code of a symbol, f for data, e for other K
  function automatic logic [3:0] kcode(input logic [9:0] s);
    logic [3:0] f;
    f = s[9:4] == 6'b001111 ? s[3:0] : ~s[3:0];
    if (s[9:4] != 6'b001111 && s[9:4] != 6'b110000)
      return 4'hf;
    case (f)
      4'b0100: return 4'h0;
      4'b0011: return 4'h3;
      4'b0010: return 4'h4;
      4'b1010: return 4'h5;
      4'b1000: return 4'h7;
      default: return 4'he;
    endcase
  endfunction
  function automatic logic [31:0] ctrlW(input int m, input int s, input int k);
    return {19'h0, 5'(k - 1), 5'h0, 1'(s), 2'(m)};
  endfunction
  function automatic logic [31:0] fchkExp(input int m, input int s, input int k);
    int lm1;
    lm1 = m == 0 ? 0 : m == 1 ? 1 : 3;
    return 32'((`CSLT_DID + `CSLT_BID + `CSLT_SUBCL + `CSLT_JESDV + 33 + s
      + k - 1 + lm1 + 8 / (lm1 + 1) - 1) % 256);
  endfunction

  // with map e4 in two-lane mode, last octet of lane 0 keeps LSB 5a; path 0 LSB changes every frame
  always @(posedge clk) begin
    kLog[cyc % 4096] <= kcode(laneSym[0]);
    cyc <= cyc + 1;
    if (sampleTake === 1'b1) begin
      lfsr <= nextRnd(lfsr);
      samples[0] <= {lfsr[15:8], samples[0][7:0] ^ {lfsr[6:0], 1'b1}};
      samples[1] <= {samples[1][15:8] ^ {lfsr[22:16], 1'b1}, 8'h5a};
      samples[2] <= lfsr[31:16];
      samples[3] <= lfsr[15:0];
    end
  end

  task automatic chkVal(input string what, input logic [31:0] exp,
                        input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge clk);
    apbReq.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (apbRsp.pready !== 1'b1 && n < 20);
    if (n >= 20)
      num_errors++;
    rd = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq <= '0;
    @(posedge clk);
  endtask
  task automatic linkUp(input int m, input int s, input int k, input int f);
    int mf, rel, n;
    logic [3:0] e, g;
    mf = k * f;
    apb(1'b1, `CSLT_REG_CTRL, ctrlW(m, s, k));
    goLink <= 1'b1;
    for (n = 0; n < 3000 && receiverSyncRequestN !== 1'b1; n++)
      @(posedge clk);
    rel = cyc;
    for (n = 0; n < 3000 && kcode(laneSym[0]) !== 4'h0; n++)
      @(posedge clk);
    c0 = cyc;
    chkVal("ilasDelay", 1, 32'(c0 - rel >= mf && c0 - rel <= 2 * mf + 3));
    repeat (7 * mf + 2) @(posedge clk);
    for (int j = 0; j < 7 * mf; j++) begin
      e = 4'hf;
      if (j % mf == 0 && j < 4 * mf)
        e = 4'h0;
      if (j == mf + 1)
        e = 4'h4;
      if (j % mf == mf - 1 && j < 4 * mf)
        e = 4'h3;
      if (j >= 5 * mf && j % f == f - 1)
        e = j % mf == mf - 1 ? 4'h3 : 4'h7;
      if (j < 4 * mf || (j >= 5 * mf && s == 0))
        chkVal("lane0Sym", 32'(e), 32'(kLog[(c0 + j) % 4096]));
      else if (s == 1) begin
        // scrambled frame ends: data, or the boundary's own character
        g = kLog[(c0 + j) % 4096];
        e = j % f != f - 1 ? 4'hf : j % mf == mf - 1 ? 4'h3 : 4'h7;
        chkVal("scrSym", 1, 32'(g == 4'hf || g == e));
      end
    end
    apb(1'b0, `CSLT_REG_STAT, 0);
    chkVal("statPhase", 2, {30'h0, rd[1:0]});
    for (n = 0; n < 20 && sampleTake !== 1'b1; n++)
      @(posedge clk);
    rel = cyc;
    @(posedge clk);
    for (n = 0; n < 20 && sampleTake !== 1'b1; n++)
      @(posedge clk);
    chkVal("takePeriod", 32'(f), 32'(cyc - rel));
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    #400000;
    num_errors++;
    give_verdict();
  end
  initial begin
    int b;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    chkVal("laneActive", 1, {28'h0, laneActive});
    apb(1'b0, `CSLT_REG_CTRL, 0);
    chkVal("ctrl", 32'h0000_1f00, rd);
    apb(1'b0, `CSLT_REG_MAP, 0);
    chkVal("map", 32'h0000_00e4, rd);
    apb(1'b1, `CSLT_REG_FCHK, 32'h0000_00ff);
    apb(1'b0, `CSLT_REG_FCHK, 0);
    chkVal("fchk", fchkExp(0, 0, 32), rd);
    apb(1'b1, 8'h44, 32'h0000_0001);
    chkVal("slverr", 1, {31'h0, err});
    apb(1'b0, 8'h40, 0);
    chkVal("slverr", 1, {31'h0, err});
    chkVal("unmapped", 0, rd);
    for (int m = 0; m < 3; m++) begin
      for (int s = 0; s < 2; s++) begin
        apb(1'b1, `CSLT_REG_CTRL, ctrlW(m, s, m * 7 + 4));
        apb(1'b0, `CSLT_REG_CTRL, 0);
        chkVal("ctrl", ctrlW(m, s, m * 7 + 4), rd);
        chkVal("laneActive", m == 0 ? 1 : m == 1 ? 3 : 15, {28'h0, laneActive});
        apb(1'b0, `CSLT_REG_FCHK, 0);
        chkVal("fchk", fchkExp(m, s, m * 7 + 4), rd);
        for (int l = 0; l < 4; l++)
          if (laneActive[l])
            chkVal("cgsSym", 5, 32'(kcode(laneSym[l])));
      end
    end
    linkUp(1, 0, 4, 4);
    apb(1'b1, `CSLT_REG_MAP, 32'h0000_00e1);
    repeat (20) @(posedge clk);
    b = cyc;
    repeat (34) @(posedge clk);
    for (int j = 0; j < 32; j++)
      if ((b + j - c0) % 4 == 3)
        chkVal("swapSym", 15, 32'(kLog[(b + j) % 4096]));
    apb(1'b1, `CSLT_REG_MAP, 32'h0000_00e4);
    goLink <= 1'b0;
    repeat (6) @(posedge clk);
    chkVal("resync", 5, 32'(kcode(laneSym[1])));
    apb(1'b0, `CSLT_REG_STAT, 0);
    chkVal("statPhase", 0, {30'h0, rd[1:0]});
    linkUp(2, 1, 8, 2);
    give_verdict();
  end
endmodule

// >>> tb/cslt_rx_model.sv
// far-side receiver model: comma lock, sysref pulse, sync release
// assumes the bench raises goLink once the transmitter is configured
`timescale 1ns/1ps
module cslt_rx_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic goLink,
  input wire logic [3:0] laneActive,
  input wire logic [3:0][9:0] laneSym,
  output logic sysref,
  output logic receiverSyncRequestN
);
  int cnt;
  logic allComma;
  always_comb begin
    allComma = 1'b1;
    for (int l = 0; l < 4; l++) begin
      if (laneActive[l] && laneSym[l] != 10'h0fa && laneSym[l] != 10'h305)
        allComma = 1'b0;
    end
  end
  // sync held low well past four multiframes after sysref
  always_ff @(posedge clk) begin
    if (!rstn || !goLink) begin
      cnt <= 0;
      sysref <= 1'b0;
      receiverSyncRequestN <= 1'b0;
    end else begin
      if (cnt < 16)
        cnt <= allComma ? cnt + 1 : 0;
      else if (cnt < 120)
        cnt <= cnt + 1;
      sysref <= cnt >= 16 && cnt < 20;
      if (cnt >= 120)
        receiverSyncRequestN <= 1'b1;
    end
  end
endmodule
